// >>> logic/qsf_cmd_front.sv
`include "qsf_defs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// byte fifo between the array read port and the output shifter
module qsf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    assign inReady = (count != DEPTH[AW:0]);
    assign outValid = (count != '0);
    assign outData = store[rdPtr];
    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge ref_clk) begin
        if (!rst_n || clear) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= wrPtr + AW'(push);
            rdPtr <= rdPtr + AW'(pop);
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end
endmodule
////////////////////////////////////////////////////////////////////////////////
module qsf_cmd_front (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // flash pins, sampled on ref_clk
    input wire logic csN,
    input wire logic sck,
    input wire logic [3:0] sioIn,
    output logic [3:0] sioOut,
    output logic [3:0] sioOe,
    // array read stream
    output logic [23:0] memAddr,
    output logic memReady,
    input wire logic memValid,
    input wire logic [7:0] memData,
    // protection map contents, byte 0 in the low bits
    input wire logic [143:0] protMap,
    // decoded commands and write data
    output qsf_pkg::qsf_cmd_type cmdEvent,
    output logic cmdValid,
    output qsf_pkg::qsf_wr_type wrEvent,
    output logic wrValid,
    // configuration and status
    input wire logic cfgWrite,
    input wire logic cfgIoValue,
    input wire logic statusWrite,
    input wire logic [7:0] statusWrData,
    input wire logic writeBusy,
    output logic quadMode,
    output logic ioConfig,
    output logic [1:0] burstLen,
    output logic [7:0] statusBits,
    output logic abortWrite,
    output logic recovering
);
    import qsf_pkg::*;

    // phase plan per opcode; lane counts already follow the mode
    function automatic qsf_plan_type planFor(input logic [7:0] op, input logic quad,
                                             input logic io_config_bit);
        qsf_plan_type p;
        p = '{legal: 1'b0, addrN: 2'h0, dummyN: 2'h0, kind: DK_NONE,
              addrLanes: quad ? 3'h4 : 3'h1, dataLanes: quad ? 3'h4 : 3'h1};
        case (op)
            `QSF_OP_SUSPEND, `QSF_OP_RESUME: p.legal = 1'b1;
            `QSF_OP_LOCKMAP, `QSF_OP_UNPROT: p.legal = 1'b1;
            `QSF_OP_SIDLOCK: p.legal = 1'b1;
            `QSF_OP_NOP, `QSF_OP_RSTARM, `QSF_OP_RESET, `QSF_OP_RQUAD: p.legal = 1'b1;
            `QSF_OP_EQUAD: p.legal = !quad;
            `QSF_OP_READ: begin
                p.legal = !quad;
                p.addrN = 2'h3;
                p.kind = DK_MEM;
            end
            `QSF_OP_QOUT: begin
                p.legal = !quad && io_config_bit;
                p.addrN = 2'h3;
                p.dummyN = 2'h1;
                p.kind = DK_MEM;
                p.dataLanes = 3'h4;
            end
            `QSF_OP_QIO: begin
                p.legal = !quad && io_config_bit;
                p.addrN = 2'h3;
                p.dummyN = 2'h3;
                p.kind = DK_MEM;
                p.addrLanes = 3'h4;
                p.dataLanes = 3'h4;
            end
            `QSF_OP_DOUT, `QSF_OP_DIO: begin
                p.legal = !quad;
                p.addrN = 2'h3;
                p.dummyN = 2'h1;
                p.kind = DK_MEM;
                p.addrLanes = (op == `QSF_OP_DIO) ? 3'h2 : 3'h1;
                p.dataLanes = 3'h2;
            end
            `QSF_OP_RDMAP: begin
                p.legal = 1'b1;
                p.dummyN = quad ? 2'h1 : 2'h0;
                p.kind = DK_PROT;
            end
            `QSF_OP_WRMAP, `QSF_OP_NVLOCK: begin
                p.legal = 1'b1;
                p.kind = DK_WMAP;
            end
            `QSF_OP_SETBURST: begin
                p.legal = 1'b1;
                p.kind = DK_BURST;
            end
            `QSF_OP_SECTOR, `QSF_OP_BLOCK: begin
                p.legal = 1'b1;
                p.addrN = 2'h3;
            end
            default: p.legal = 1'b0;
        endcase
        return p;
    endfunction

    // erase granularity: 8 KByte and 32 KByte blocks sit in the outer 64 KByte at each end
    function automatic logic [23:0] targetAddr(input logic [7:0] op, input logic [23:0] a);
        logic [23:0] m;
        logic top;
        logic bottom;
        m = a & `QSF_ADDR_MASK;
        top = (m[23:16] == 8'hff);
        bottom = (m[23:16] == 8'h00);
        if (op == `QSF_OP_SECTOR) begin
            m[11:0] = 12'h000;
        end else if (op == `QSF_OP_BLOCK) begin
            if ((bottom && !m[15]) || (top && m[15])) begin
                m[12:0] = 13'h0000;
            end else if (bottom || top) begin
                m[14:0] = 15'h0000;
            end else begin
                m[15:0] = 16'h0000;
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin edges and shared wires
    logic sckPrev;
    qsf_state_type state;
    qsf_state_type next_state;
    qsf_plan_type plan;
    logic [3:0] bitCnt;
    logic [4:0] byteCnt;
    logic [7:0] inShift;
    logic [7:0] opcode;
    logic [23:0] addrReg;
    logic [7:0] outByte;
    logic [3:0] outCnt;
    logic resetArmed;
    logic fetchEn;
    logic [7:0] recoverCnt;
    logic [2:0] lanes;
    logic [7:0] fifoData;
    logic fifoValid;
    logic fifoInReady;
    logic [4:0] fifoCount;

    wire sckRise = sck && !sckPrev && !csN;
    wire sckFall = !sck && sckPrev && !csN;
    wire [3:0] laneSum = bitCnt + {1'b0, lanes};
    wire byteDone = sckRise && (laneSum == 4'h8);
    wire [7:0] rxByte = (lanes == 3'h4) ? {inShift[3:0], sioIn} :
                        (lanes == 3'h2) ? {inShift[5:0], sioIn[1:0]} : {inShift[6:0], sioIn[0]};
    wire opcDone = byteDone && (state == ST_OPC);
    wire qsf_plan_type opPlan = planFor(rxByte, quadMode, ioConfig);
    wire swResetFire = opcDone && (rxByte == `QSF_OP_RESET) && resetArmed;
    wire addrDone = byteDone && (state == ST_ADDR) && (byteCnt == 5'h2);
    wire [23:0] fullAddr = {addrReg[15:0], rxByte};
    wire [7:0] mapByte = protMap[8 * byteCnt +: 8];
    wire [7:0] srcByte = (plan.kind == DK_PROT) ? mapByte : fifoData;
    wire loadNow = sckFall && (state == ST_RDATA) && (outCnt == 4'h0);
    wire [7:0] txByte = loadNow ? srcByte : outByte;
    wire fifoPop = loadNow && (plan.kind == DK_MEM) && fifoValid;
    wire memPush = memValid && memReady && fifoInReady;
    wire [23:0] addrMax = `QSF_ADDR_MASK;
    wire [3:0] laneSumOut = outCnt + {1'b0, lanes};

    // lane count of the phase in progress
    assign lanes = (state == ST_OPC) ? (quadMode ? 3'h4 : 3'h1) :
                   (state == ST_RDATA) ? plan.dataLanes :
                   (state == ST_ADDR || state == ST_DUMMY) ? plan.addrLanes :
                   (quadMode ? 3'h4 : 3'h1);

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencing: opcode, address and dummy phases end on the rising clock that completes a byte; data and ignore phases end at chip select
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = (!csN) ? (recovering ? ST_IGNORE : ST_OPC) : ST_IDLE;
            ST_OPC: begin
                if (opcDone) begin
                    if (!opPlan.legal) begin
                        next_state = ST_IGNORE;
                    end else if (opPlan.addrN != 2'h0) begin
                        next_state = ST_ADDR;
                    end else if (opPlan.dummyN != 2'h0) begin
                        next_state = ST_DUMMY;
                    end else if (opPlan.kind == DK_PROT) begin
                        next_state = ST_RDATA;
                    end else if (opPlan.kind == DK_NONE) begin
                        next_state = ST_IGNORE;
                    end else begin
                        next_state = ST_WDATA;
                    end
                end
            end
            ST_ADDR: begin
                if (addrDone) begin
                    next_state = (plan.dummyN != 2'h0) ? ST_DUMMY :
                                 (plan.kind == DK_MEM) ? ST_RDATA : ST_IGNORE;
                end
            end
            ST_DUMMY: begin
                if (byteDone && (byteCnt == {3'h0, plan.dummyN} - 5'h1)) begin
                    next_state = ST_RDATA;
                end
            end
            ST_RDATA, ST_WDATA, ST_IGNORE: next_state = state;
            default: next_state = ST_IGNORE;
        endcase
        if (csN) begin
            next_state = ST_IDLE;
        end
    end

    // frame state; chip select high ends everything a frame holds
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            sckPrev <= 1'b0;
            bitCnt <= 4'h0;
            byteCnt <= 5'h0;
            inShift <= 8'h00;
        end else begin
            state <= next_state;
            sckPrev <= sck;
            if (csN || (byteDone && next_state != state)) begin
                bitCnt <= 4'h0;
                byteCnt <= 5'h0;
            end else if (sckRise && state != ST_RDATA) begin
                bitCnt <= byteDone ? 4'h0 : laneSum;
                inShift <= rxByte;
                // saturates so that a long map write cannot wrap back into range
                byteCnt <= byteCnt + 5'(byteDone && byteCnt != 5'h1f);
            end else if (loadNow) begin
                byteCnt <= (byteCnt == `QSF_MAP_BYTES - 5'h1) ? 5'h0 : byteCnt + 5'h1;
            end
        end
    end

    // opcode, plan and address capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opcode <= 8'h00;
            plan <= '0;
            addrReg <= 24'h000000;
        end else if (opcDone) begin
            opcode <= rxByte;
            plan <= opPlan;
        end else if (byteDone && state == ST_ADDR) begin
            addrReg <= fullAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command events; commands without an address report at opcode end, the others at address end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmdValid <= 1'b0;
            cmdEvent <= '0;
            wrValid <= 1'b0;
            wrEvent <= '0;
        end else begin
            cmdValid <= (opcDone && opPlan.legal && opPlan.addrN == 2'h0) || addrDone;
            if (opcDone) begin
                cmdEvent <= '{opcode: rxByte, addr: 24'h000000};
            end else if (addrDone) begin
                cmdEvent <= '{opcode: opcode, addr: targetAddr(opcode, fullAddr)};
            end
            // bytes past the eighteenth are dropped
            wrValid <= byteDone && state == ST_WDATA && plan.kind == DK_WMAP &&
                       byteCnt < `QSF_MAP_BYTES;
            if (byteDone && state == ST_WDATA) begin
                wrEvent <= '{opcode: opcode, index: byteCnt, data: rxByte};
            end
        end
    end

    // mode, burst, configuration and status; software reset overrides a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            quadMode <= 1'b0;
            burstLen <= `QSF_BURST_RST;
            ioConfig <= 1'b0;
            statusBits <= `QSF_STATUS_RST;
            resetArmed <= 1'b0;
        end else begin
            if (opcDone) begin
                resetArmed <= (rxByte == `QSF_OP_RSTARM);
            end
            if (swResetFire) begin
                quadMode <= 1'b0;
                burstLen <= `QSF_BURST_RST;
                ioConfig <= 1'b0;
                statusBits <= (statusBits & `QSF_STATUS_KEEP) |
                              (`QSF_STATUS_RST & ~`QSF_STATUS_KEEP);
            end else begin
                if (opcDone && rxByte == `QSF_OP_EQUAD && !quadMode) begin
                    quadMode <= 1'b1;
                end else if (opcDone && rxByte == `QSF_OP_RQUAD) begin
                    quadMode <= 1'b0;
                end
                if (byteDone && state == ST_WDATA && plan.kind == DK_BURST && byteCnt == 5'h0) begin
                    burstLen <= rxByte[1:0];
                end
                if (cfgWrite) begin
                    ioConfig <= cfgIoValue;
                end
                if (statusWrite) begin
                    statusBits <= statusWrData;
                end
            end
        end
    end

    // a reset during a write aborts it and waits the longer recovery
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            abortWrite <= 1'b0;
            recoverCnt <= 8'h00;
            recovering <= 1'b0;
        end else begin
            abortWrite <= swResetFire && writeBusy;
            if (swResetFire) begin
                recoverCnt <= writeBusy ? 8'(`QSF_RECOVER_WR_CYC) : 8'(`QSF_RECOVER_CYC);
                recovering <= 1'b1;
            end else if (recoverCnt != 8'h00) begin
                recoverCnt <= recoverCnt - 8'h01;
                recovering <= (recoverCnt != 8'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array fetch runs ahead of the shifter; ready is registered, so it stops two short of full
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fetchEn <= 1'b0;
            memAddr <= 24'h000000;
            memReady <= 1'b0;
        end else begin
            if (csN) begin
                fetchEn <= 1'b0;
            end else if (addrDone && plan.kind == DK_MEM) begin
                fetchEn <= 1'b1;
            end
            if (addrDone) begin
                memAddr <= fullAddr & `QSF_ADDR_MASK;
            end else if (memPush) begin
                memAddr <= (memAddr == addrMax) ? 24'h000000 : memAddr + 24'h1;
            end
            memReady <= fetchEn && !csN && (fifoCount < 5'(`QSF_FIFO_DEPTH - 2));
        end
    end

    qsf_fifo #(.WIDTH(8), .DEPTH(`QSF_FIFO_DEPTH)) readFifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(csN),
        .inValid(memValid && memReady),
        .inReady(fifoInReady),
        .inData(memData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData),
        .count(fifoCount)
    );

    // output shifter drives on the falling clock; single line answers on lane 1
    always_ff @(posedge ref_clk) begin
        if (!rst_n || csN) begin
            outByte <= 8'h00;
            outCnt <= 4'h0;
            sioOut <= 4'h0;
            sioOe <= 4'h0;
        end else if (sckFall && state == ST_RDATA) begin
            outByte <= txByte << lanes;
            outCnt <= (laneSumOut == 4'h8) ? 4'h0 : laneSumOut;
            case (lanes)
                3'h4: begin
                    sioOut <= txByte[7:4];
                    sioOe <= 4'hf;
                end
                3'h2: begin
                    sioOut <= {2'h0, txByte[7:6]};
                    sioOe <= 4'h3;
                end
                default: begin
                    sioOut <= {2'h0, txByte[7], 1'b0};
                    sioOe <= 4'h2;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] opcRises;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state != ST_OPC) begin
            opcRises <= 4'h0;
        end else if (sckRise) begin
            opcRises <= opcRises + 4'h1;
        end
    end

    chk_opcode_len: assert property (
        opcDone |-> (opcRises + 4'h1 == (quadMode ? 4'h2 : 4'h8)))
        else $error("opcode length wrong for mode");
    chk_reset_armed: assert property (
        (opcDone && rxByte == `QSF_OP_RESET && !resetArmed) |=> !abortWrite && !$rose(recovering))
        else $error("reset ran without reset arm");
    chk_reset_mode: assert property (
        swResetFire |=> !quadMode && burstLen == 2'h0 && !ioConfig)
        else $error("reset left mode or burst length");
    chk_status_keep: assert property (
        swResetFire |=> statusBits[5:4] == $past(statusBits[5:4]) && statusBits[3:0] == 4'h0)
        else $error("reset status bits wrong");
    chk_abort_write: assert property (
        (swResetFire && writeBusy) |=> abortWrite ##1 recovering [*8])
        else $error("write not aborted");
    chk_nop_only: assert property (
        (opcDone && rxByte == `QSF_OP_NOP) |=> !resetArmed && $stable(quadMode) && !wrValid)
        else $error("no-operation had an effect");
    chk_read_single: assert property (
        (state == ST_ADDR && opcode == `QSF_OP_READ) |-> !quadMode)
        else $error("plain read taken in quad mode");
    chk_addr_wrap: assert property (
        (memPush && memAddr == addrMax) |=> memAddr == 24'h000000)
        else $error("read address did not wrap");
    chk_sector_align: assert property (
        (cmdValid && cmdEvent.opcode == `QSF_OP_SECTOR) |-> cmdEvent.addr[11:0] == 12'h000)
        else $error("sector address not aligned");
    chk_unknown_hold: assert property (
        (opcDone && !opPlan.legal) |=> (state == ST_IGNORE) until csN)
        else $error("unknown opcode not ignored");
endmodule
`default_nettype wire

// >>> logic/qsf_defs.svh
// Notes on behaviour
// - opcode takes two clocks quad, eight single
// - address, dummy, data bytes: two, four or eight clocks
// - address bits above array density are ignored
// - quad output read: four-lane data, needs IO config
// - quad io read: four-lane address onward, needs config
// - dual reads: four-clock data, dual io address too
// - sector erase keeps bits down to 12
// - block erase decodes 64/32/8 KByte by location
// - no-operation only cancels a pending reset arm
// - reset runs only directly after reset arm
// - reset restores single-line mode, burst length eight
// - reset defaults status except bits 4,5; clears io config
// - reset aborts running write; longer recovery after write
// - plain read only in single-line mode
// - plain read: opcode, 24 address bits, no dummy
// - streaming read increments address, wraps to zero
// - suspend and resume take only the opcode
// - protect map read: dummy byte only in quad
// - protect map writes take 1 to 18 bytes
// - lock map and global unprotect: opcode only
// - secure id lockout: opcode only, either mode
// - enable quad switches all later commands to quad
// - burst length defaults to code 00h
`ifndef QSF_DEFS_SVH
`define QSF_DEFS_SVH
// opcodes
`define QSF_OP_SUSPEND 8'hb0
`define QSF_OP_RESUME 8'h30
`define QSF_OP_RDMAP 8'h72
`define QSF_OP_WRMAP 8'h42
`define QSF_OP_LOCKMAP 8'h8d
`define QSF_OP_NVLOCK 8'he8
`define QSF_OP_UNPROT 8'h98
`define QSF_OP_SIDLOCK 8'h85
`define QSF_OP_NOP 8'h00
`define QSF_OP_RSTARM 8'h66
`define QSF_OP_RESET 8'h99
`define QSF_OP_EQUAD 8'h38
`define QSF_OP_RQUAD 8'hff
`define QSF_OP_READ 8'h03
`define QSF_OP_QOUT 8'h6b
`define QSF_OP_QIO 8'heb
`define QSF_OP_DOUT 8'h3b
`define QSF_OP_DIO 8'hbb
`define QSF_OP_SETBURST 8'hc0
`define QSF_OP_SECTOR 8'h20
`define QSF_OP_BLOCK 8'hd8
// array and map geometry
`define QSF_ADDR_BITS 24
`define QSF_ADDR_MASK 24'hffffff
`define QSF_MAP_BYTES 5'h12
`define QSF_FIFO_DEPTH 16
// reset values
`define QSF_STATUS_RST 8'h00
`define QSF_STATUS_KEEP 8'h30
`define QSF_BURST_RST 2'h0
// recovery after software reset
`define QSF_CLK_NS 5
`define QSF_RECOVER_NS 100
`define QSF_RECOVER_WR_NS 1000
`define QSF_RECOVER_CYC ((`QSF_RECOVER_NS + `QSF_CLK_NS - 1) / `QSF_CLK_NS)
`define QSF_RECOVER_WR_CYC ((`QSF_RECOVER_WR_NS + `QSF_CLK_NS - 1) / `QSF_CLK_NS)
`endif

// >>> logic/qsf_pkg.sv
`default_nettype none
package qsf_pkg;
    typedef enum logic [2:0] {DK_NONE, DK_MEM, DK_PROT, DK_WMAP, DK_BURST} qsf_kind_type;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_IGNORE
    } qsf_state_type;
    // phase plan of one command
    typedef struct packed {
        logic legal;
        logic [1:0] addrN;
        logic [1:0] dummyN;
        qsf_kind_type kind;
        logic [2:0] addrLanes;
        logic [2:0] dataLanes;
    } qsf_plan_type;
    // decoded command handed to the array side
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
    } qsf_cmd_type;
    // one data byte of a map write
    typedef struct packed {
        logic [7:0] opcode;
        logic [4:0] index;
        logic [7:0] data;
    } qsf_wr_type;
endpackage
`default_nettype wire

// >>> dv/qsf_host.sv
`default_nettype none
module qsf_host (
    // pins of the block
    input wire logic ref_clk,
    input wire logic [3:0] sioOut,
    output logic csN,
    output logic sck,
    output logic [3:0] sioIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: deselected, clock parked low outside frames
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        sioIn = 4'h5;
    end
    // one byte on 1 or 4 lanes, msb first, 3 low and 3 high cycles a clock
    task automatic put(input logic [7:0] b, input int w);
        for (int k = 8 / w - 1; k >= 0; k--) begin
            @(posedge ref_clk);
            sck <= 1'b0;
            sioIn <= 4'((b >> (k * w)) & ((1 << w) - 1));
            repeat (3) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    // single-lane byte in, sampled mid-cycle so the block's own edge has landed
    task automatic get(output logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            sck <= 1'b0;
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            b = {b[6:0], sioOut[1]};
            @(posedge ref_clk);
            sck <= 1'b1;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task automatic open();
        @(posedge ref_clk);
        csN <= 1'b0;
    endtask
    // every command ends its own frame; released lines show a changed level
    task automatic close();
        @(posedge ref_clk);
        sck <= 1'b0;
        repeat (2) @(posedge ref_clk);
        csN <= 1'b1;
        sioIn <= ~sioIn;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> dv/quad_serial_flash_cmd_front_tb_top.sv
`default_nettype none
module quad_serial_flash_cmd_front_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, gate = 1'b0, memValid, csN, sck, memReady;
    logic cfgWrite = 1'b0, cfgIoValue = 1'b0, statusWrite = 1'b0, writeBusy = 1'b0;
    logic cmdValid, wrValid, quadMode, ioConfig, abortWrite, recovering;
    logic [3:0] sioIn, sioOut, sioOe;
    logic [23:0] memAddr, tagAddr, ea[4], ee[4];
    logic [7:0] memData, statusWrData = 8'h00, statusBits, b0, b1;
    logic [1:0] burstLen;
    logic [31:0] seed = 32'h57d2da3f;
    qsf_pkg::qsf_cmd_type cmdEvent;
    qsf_pkg::qsf_wr_type wrEvent;
    int error_cnt = 0, n_compared = 0, cyc = 0, nCmd = 0, nAbort = 0;
    logic [143:0] protMap = 144'ha53c;
    qsf_host host (.ref_clk(ref_clk), .sioOut(sioOut), .csN(csN), .sck(sck), .sioIn(sioIn));
    qsf_cmd_front DUT (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .sck(sck), .sioIn(sioIn),
        .sioOut(sioOut), .sioOe(sioOe), .memAddr(memAddr), .memReady(memReady),
        .memValid(memValid), .memData(memData), .protMap(protMap), .cmdEvent(cmdEvent),
        .cmdValid(cmdValid), .wrEvent(wrEvent), .wrValid(wrValid), .cfgWrite(cfgWrite),
        .cfgIoValue(cfgIoValue), .statusWrite(statusWrite), .statusWrData(statusWrData),
        .writeBusy(writeBusy), .quadMode(quadMode), .ioConfig(ioConfig), .burstLen(burstLen),
        .statusBits(statusBits), .abortWrite(abortWrite), .recovering(recovering));
    always #2.5 ref_clk = ~ref_clk;
    function automatic logic [7:0] memOf(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h5a;
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // array stand-in answers every other cycle, so the fifo sees stalls
    always @(posedge ref_clk) begin
        memData <= memOf(memAddr);
        tagAddr <= memAddr;
        gate <= ~gate;
        cyc <= cyc + 1;
        nCmd <= nCmd + (cmdValid === 1'b1);
        nAbort <= nAbort + (abortWrite === 1'b1);
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    assign memValid = gate && (tagAddr === memAddr);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int w, input int n, input logic [23:0] d);
        host.open();
        host.put(op, w);
        for (int i = n - 1; i >= 0; i--) host.put(d[i*8+:8], w);
        host.close();
    endtask
    task automatic results();
        $display("compared %0d, wrong %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence: erase decode, reset arming, plain read with wrap
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({quadMode, burstLen, statusBits}, 0);
        ea = '{24'(rnd()), {8'h45, 16'(rnd())}, {11'h001, 13'(rnd())}, {9'h001, 15'(rnd())}};
        ee = '{{ea[0][23:12], 12'h0}, 24'h450000, 24'h002000, 24'h008000};
        for (int i = 0; i < 4; i++) begin
            cmd(i == 0 ? 8'h20 : 8'hd8, 1, 3, ea[i]);
            check(cmdEvent, {i == 0 ? 8'h20 : 8'hd8, ee[i]});
        end
        check(nCmd, 4);
        statusWrData <= 8'(rnd());
        {statusWrite, cfgWrite, cfgIoValue} <= 3'h7;
        @(posedge ref_clk);
        {statusWrite, cfgWrite} <= 2'h0;
        cmd(8'hc0, 1, 1, 24'h3);
        cmd(8'h38, 1, 0, 0);
        cmd(8'h66, 4, 0, 0);
        cmd(8'h00, 4, 0, 0);
        cmd(8'h99, 4, 0, 0);
        check({quadMode, ioConfig, burstLen, statusBits}, {4'hf, statusWrData});
        writeBusy <= 1'b1;
        cmd(8'h66, 4, 0, 0);
        cmd(8'h99, 4, 0, 0);
        check({recovering, quadMode, ioConfig, burstLen, statusBits}, {5'h10, statusWrData & 8'h30});
        check(nAbort, 1);
        writeBusy <= 1'b0;
        repeat (250) @(posedge ref_clk);
        host.open();
        host.put(8'h03, 1);
        repeat (3) host.put(8'hff, 1);
        repeat (20) @(posedge ref_clk);
        host.get(b0);
        host.get(b1);
        check(sioOe, 4'h2);
        host.close();
        check({b0, b1}, {memOf(24'hffffff), memOf(24'h0)});
        // map read in single-line mode has no dummy byte
        host.open();
        host.put(8'h72, 1);
        host.get(b0);
        host.get(b1);
        host.close();
        check({b0, b1}, 16'h3ca5);
        b0 = 8'(rnd());
        cmd(8'h42, 1, 1, {16'h0, b0});
        check(wrEvent, {8'h42, 5'h0, b0});
        results();
    end
endmodule
`default_nettype wire
